// >>> tbc_pkg.sv
package tbc_pkg;
   // ==========================================================
   // inputs and sample format
   localparam int N_IN = 20;
   localparam int SAMPLE_W = 12;
   localparam int DIG_W = N_IN * SAMPLE_W;
   localparam int IDX_W = 5;
   localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(N_IN - 1);

   // ==========================================================
   // wideband capture memory, per input
   localparam longint MEM_MBYTES = 64'd32;
   localparam longint MEM_BYTES = MEM_MBYTES * 64'd1048576;
   localparam int BITADDR_W = 29;
   localparam logic [BITADDR_W-1:0] MEM_BITS = BITADDR_W'(MEM_BYTES * 64'd8);
   localparam int RD_ADDR_W = 23;
   localparam logic [RD_ADDR_W-1:0] RD_LAST = RD_ADDR_W'(MEM_BYTES / 64'd4 - 64'd1);
   localparam int OUT_W = 32;

   // bits kept per sample
   localparam logic [1:0] BITS_SEL_12 = 2'h0;
   localparam logic [1:0] BITS_SEL_8 = 2'h1;
   localparam logic [3:0] NBITS_12 = 4'hC;
   localparam logic [3:0] NBITS_8 = 4'h8;
   localparam logic [3:0] NBITS_4 = 4'h4;

   // ==========================================================
   // narrowband downconverter
   localparam int PHASE_W = 32;
   localparam longint FS_MHZ = 64'd196;
   localparam longint TUNE_MIN_MHZ = 64'd10;
   localparam longint TUNE_MAX_MHZ = 64'd88;
   localparam logic [PHASE_W-1:0] FTW_MIN = PHASE_W'((TUNE_MIN_MHZ << 32) / FS_MHZ);
   localparam logic [PHASE_W-1:0] FTW_MAX = PHASE_W'((TUNE_MAX_MHZ << 32) / FS_MHZ);
   localparam int BW_W = 7;
   localparam logic [BW_W-1:0] BW_MIN_KHZ = 7'h01;
   localparam logic [BW_W-1:0] BW_MAX_KHZ = 7'h64;
   localparam int DECIM_W = 16;
   localparam logic [DECIM_W-1:0] DECIM_AT_MAX_BW = 16'h01F4;
   localparam logic [DECIM_W-1:0] DECIM_NUM = DECIM_W'(DECIM_AT_MAX_BW * BW_MAX_KHZ);
   localparam int LUT_W = 8;
   localparam int ACC_W = 36;
   localparam int NB_W = 16;
   localparam logic [3:0] COS_OFFSET = 4'h4;

   typedef enum logic [2:0] {
      WB_ARMED,
      WB_CAPTURE,
      WB_FULL,
      WB_READOUT,
      WB_DONE
   } tbc_wb_state_e;

   // 16-point sine, scaled to 127
   function automatic logic signed [LUT_W-1:0] tbc_sine(input logic [3:0] idx);
      case (idx)
         4'h0, 4'h8: tbc_sine = 8'h00;
         4'h1, 4'h7: tbc_sine = 8'h31;
         4'h2, 4'h6: tbc_sine = 8'h5A;
         4'h3, 4'h5: tbc_sine = 8'h75;
         4'h4: tbc_sine = 8'h7F;
         4'h9, 4'hF: tbc_sine = 8'hCF;
         4'hA, 4'hE: tbc_sine = 8'hA6;
         4'hB, 4'hD: tbc_sine = 8'h8B;
         default: tbc_sine = 8'h81;
      endcase
   endfunction : tbc_sine
endpackage : tbc_pkg

// >>> tbc_skid.sv
module tbc_skid #(
   parameter int W = 32
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // filling side
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   // draining side
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   logic spare_valid;
   logic [W-1:0] spare_data;
   logic next_out_valid;
   logic [W-1:0] next_out_data;
   logic next_spare_valid;
   logic [W-1:0] next_spare_data;

   assign in_ready = ~spare_valid;

   // ==========================================================
   // two entries: output register plus one spare
   always_comb begin
      next_out_valid = out_valid;
      next_out_data = out_data;
      next_spare_valid = spare_valid;
      next_spare_data = spare_data;
      if (out_ready || !out_valid) begin
         if (spare_valid) begin
            next_out_valid = 1'b1;
            next_out_data = spare_data;
            next_spare_valid = 1'b0;
         end else begin
            next_out_valid = in_valid;
            next_out_data = in_data;
         end
      end else if (in_valid && !spare_valid) begin
         next_spare_valid = 1'b1;
         next_spare_data = in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         out_valid <= 1'b0;
         out_data <= '0;
         spare_valid <= 1'b0;
         spare_data <= '0;
      end else begin
         out_valid <= next_out_valid;
         out_data <= next_out_data;
         spare_valid <= next_spare_valid;
         spare_data <= next_spare_data;
      end
   end
endmodule : tbc_skid

// >>> tbc_capture.sv
// Function
// - trigger starts capture; stop when memory full
// - 32 MB of capture memory per input
// - keep 12, 8 or 4 bits per sample
// - readout only after capture, own pace
// - only one mode feeds the output
// - all inputs captured together, time-aligned
// - narrowband mixes, filters, decimates, runs continuously
// - tuning held within 10 to 88 MHz
// - bandwidth 1 to 100 kHz sets decimation
// - decimate 500 at widest; multiplex all inputs
module tbc_capture (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // digitizer samples
   input wire logic dig_valid,
   input wire logic [tbc_pkg::DIG_W-1:0] dig_data,
   // control
   input wire logic trigger,
   input wire logic rearm,
   input wire logic readout_start,
   input wire logic mode_narrow,
   input wire logic [1:0] bits_sel,
   input wire logic [tbc_pkg::PHASE_W-1:0] tune_ftw,
   input wire logic [tbc_pkg::BW_W-1:0] bw_khz,
   // capture memory write port
   output logic mem_wr_en,
   output logic [tbc_pkg::BITADDR_W-1:0] mem_wr_bitaddr,
   output logic [3:0] mem_wr_bits,
   output logic [tbc_pkg::DIG_W-1:0] mem_wr_data,
   // capture memory read port
   output logic mem_rd_en,
   output logic [tbc_pkg::IDX_W-1:0] mem_rd_input,
   output logic [tbc_pkg::RD_ADDR_W-1:0] mem_rd_addr,
   input wire logic mem_rd_valid,
   input wire logic [tbc_pkg::OUT_W-1:0] mem_rd_data,
   // recorder stream
   output logic out_valid,
   output logic [tbc_pkg::OUT_W-1:0] out_data,
   input wire logic out_ready,
   // status
   output logic wb_armed,
   output logic wb_capturing,
   output logic wb_full,
   output logic wb_read_done,
   output logic nb_active,
   output logic nb_overrun
);
   // ==========================================================
   // pin synchronisers
   logic dig_valid_m, dig_valid_s;
   logic [tbc_pkg::DIG_W-1:0] dig_data_m, dig_data_s;
   logic trig_m, trig_s, trig_d;
   logic trig_edge;

   always_ff @(posedge clk) begin
      if (reset) begin
         dig_valid_m <= 1'b0;
         dig_valid_s <= 1'b0;
         dig_data_m <= '0;
         dig_data_s <= '0;
         trig_m <= 1'b0;
         trig_s <= 1'b0;
         trig_d <= 1'b0;
      end else begin
         dig_valid_m <= dig_valid;
         dig_valid_s <= dig_valid_m;
         dig_data_m <= dig_data;
         dig_data_s <= dig_data_m;
         trig_m <= trigger;
         trig_s <= trig_m;
         trig_d <= trig_s;
      end
   end
   assign trig_edge = trig_s & ~trig_d;

   // ==========================================================
   // wideband capture and readout
   tbc_pkg::tbc_wb_state_e wb_state, next_wb_state;
   logic mode_nb, next_mode_nb;
   logic [tbc_pkg::BITADDR_W-1:0] bitaddr, next_bitaddr;
   logic [3:0] nbits;
   logic [tbc_pkg::SAMPLE_W-1:0] keep_mask;
   logic [tbc_pkg::DIG_W-1:0] masked;
   logic rd_busy, next_rd_busy;
   logic next_mem_wr_en, next_mem_rd_en;
   logic [tbc_pkg::BITADDR_W-1:0] next_mem_wr_bitaddr;
   logic [3:0] next_mem_wr_bits;
   logic [tbc_pkg::DIG_W-1:0] next_mem_wr_data;
   logic [tbc_pkg::IDX_W-1:0] next_mem_rd_input;
   logic [tbc_pkg::RD_ADDR_W-1:0] next_mem_rd_addr;
   logic wb_push;
   logic buf_in_ready;

   always_comb begin
      case (bits_sel)
         tbc_pkg::BITS_SEL_12: nbits = tbc_pkg::NBITS_12;
         tbc_pkg::BITS_SEL_8: nbits = tbc_pkg::NBITS_8;
         default: nbits = tbc_pkg::NBITS_4;
      endcase
      keep_mask = ~(tbc_pkg::SAMPLE_W'(12'hFFF) >> nbits);
      for (int k = 0; k < tbc_pkg::N_IN; k++) begin
         masked[k*tbc_pkg::SAMPLE_W +: tbc_pkg::SAMPLE_W] =
            dig_data_s[k*tbc_pkg::SAMPLE_W +: tbc_pkg::SAMPLE_W] & keep_mask;
      end
   end

   assign wb_push = (wb_state == tbc_pkg::WB_READOUT) && rd_busy && mem_rd_valid;

   always_comb begin
      next_wb_state = wb_state;
      next_mode_nb = mode_nb;
      next_bitaddr = bitaddr;
      next_rd_busy = rd_busy;
      next_mem_wr_en = 1'b0;
      next_mem_wr_bitaddr = mem_wr_bitaddr;
      next_mem_wr_bits = mem_wr_bits;
      next_mem_wr_data = mem_wr_data;
      next_mem_rd_en = 1'b0;
      next_mem_rd_input = mem_rd_input;
      next_mem_rd_addr = mem_rd_addr;
      case (wb_state)
         tbc_pkg::WB_ARMED: begin
            if (!mode_nb && trig_edge) begin
               next_wb_state = tbc_pkg::WB_CAPTURE;
               next_bitaddr = '0;
            end else begin
               // mode frozen on the capture edge so both never run at once
               next_mode_nb = mode_narrow;
            end
         end
         tbc_pkg::WB_CAPTURE: begin
            if (dig_valid_s) begin
               // every input written in the same cycle keeps alignment
               next_mem_wr_en = 1'b1;
               next_mem_wr_bitaddr = bitaddr;
               next_mem_wr_bits = nbits;
               next_mem_wr_data = masked;
               next_bitaddr = bitaddr + tbc_pkg::BITADDR_W'(nbits);
               if (bitaddr + tbc_pkg::BITADDR_W'({nbits, 1'b0}) > tbc_pkg::MEM_BITS) begin
                  next_wb_state = tbc_pkg::WB_FULL;
               end
            end
         end
         tbc_pkg::WB_FULL: begin
            if (readout_start) begin
               next_wb_state = tbc_pkg::WB_READOUT;
               next_mem_rd_input = '0;
               next_mem_rd_addr = '0;
               next_rd_busy = 1'b0;
            end
         end
         tbc_pkg::WB_READOUT: begin
            if (!rd_busy && buf_in_ready) begin
               next_mem_rd_en = 1'b1;
               next_rd_busy = 1'b1;
            end
            if (wb_push) begin
               next_rd_busy = 1'b0;
               if (mem_rd_addr == tbc_pkg::RD_LAST) begin
                  next_mem_rd_addr = '0;
                  if (mem_rd_input == tbc_pkg::IDX_LAST) begin
                     next_wb_state = tbc_pkg::WB_DONE;
                  end else begin
                     next_mem_rd_input = mem_rd_input + 1'b1;
                  end
               end else begin
                  next_mem_rd_addr = mem_rd_addr + 1'b1;
               end
            end
         end
         tbc_pkg::WB_DONE: begin
            next_mode_nb = mode_narrow;
            if (rearm) begin
               next_wb_state = tbc_pkg::WB_ARMED;
            end
         end
         default: next_wb_state = tbc_pkg::WB_ARMED;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wb_state <= tbc_pkg::WB_ARMED;
         mode_nb <= 1'b0;
         bitaddr <= '0;
         rd_busy <= 1'b0;
         mem_wr_en <= 1'b0;
         mem_wr_bitaddr <= '0;
         mem_wr_bits <= '0;
         mem_wr_data <= '0;
         mem_rd_en <= 1'b0;
         mem_rd_input <= '0;
         mem_rd_addr <= '0;
         wb_armed <= 1'b0;
         wb_capturing <= 1'b0;
         wb_full <= 1'b0;
         wb_read_done <= 1'b0;
         nb_active <= 1'b0;
      end else begin
         wb_state <= next_wb_state;
         mode_nb <= next_mode_nb;
         bitaddr <= next_bitaddr;
         rd_busy <= next_rd_busy;
         mem_wr_en <= next_mem_wr_en;
         mem_wr_bitaddr <= next_mem_wr_bitaddr;
         mem_wr_bits <= next_mem_wr_bits;
         mem_wr_data <= next_mem_wr_data;
         mem_rd_en <= next_mem_rd_en;
         mem_rd_input <= next_mem_rd_input;
         mem_rd_addr <= next_mem_rd_addr;
         wb_armed <= (next_wb_state == tbc_pkg::WB_ARMED) && !next_mode_nb;
         wb_capturing <= next_wb_state == tbc_pkg::WB_CAPTURE;
         wb_full <= next_wb_state == tbc_pkg::WB_FULL;
         wb_read_done <= next_wb_state == tbc_pkg::WB_DONE;
         nb_active <= next_mode_nb;
      end
   end

   // ==========================================================
   // narrowband downconvert, boxcar filter, decimate, multiplex
   logic [tbc_pkg::PHASE_W-1:0] phase, next_phase, ftw_eff;
   logic [tbc_pkg::BW_W-1:0] bw_eff;
   logic [tbc_pkg::DECIM_W-1:0] decim, next_decim, decim_cnt, next_decim_cnt;
   logic signed [tbc_pkg::ACC_W-1:0] acc_i [tbc_pkg::N_IN];
   logic signed [tbc_pkg::ACC_W-1:0] acc_q [tbc_pkg::N_IN];
   logic signed [tbc_pkg::ACC_W-1:0] next_acc_i [tbc_pkg::N_IN];
   logic signed [tbc_pkg::ACC_W-1:0] next_acc_q [tbc_pkg::N_IN];
   logic [tbc_pkg::OUT_W-1:0] hold [tbc_pkg::N_IN];
   logic [tbc_pkg::OUT_W-1:0] next_hold [tbc_pkg::N_IN];
   logic signed [tbc_pkg::LUT_W-1:0] sin_v, cos_v;
   logic signed [tbc_pkg::ACC_W-1:0] sum_i, sum_q;
   logic nb_step, nb_dump, nb_push;
   logic nb_sending, next_nb_sending;
   logic [tbc_pkg::IDX_W-1:0] nb_idx, next_nb_idx;
   logic next_nb_overrun;

   assign nb_step = mode_nb && dig_valid_s;
   assign nb_dump = nb_step && (decim_cnt == decim - 1'b1);
   // a frame left over from an earlier narrowband run stalls in wideband mode
   assign nb_push = mode_nb && nb_sending && buf_in_ready;

   always_comb begin
      if (tune_ftw < tbc_pkg::FTW_MIN) ftw_eff = tbc_pkg::FTW_MIN;
      else if (tune_ftw > tbc_pkg::FTW_MAX) ftw_eff = tbc_pkg::FTW_MAX;
      else ftw_eff = tune_ftw;
      if (bw_khz < tbc_pkg::BW_MIN_KHZ) bw_eff = tbc_pkg::BW_MIN_KHZ;
      else if (bw_khz > tbc_pkg::BW_MAX_KHZ) bw_eff = tbc_pkg::BW_MAX_KHZ;
      else bw_eff = bw_khz;
      // 500 at 100 kHz, scaled up as the bandwidth narrows
      next_decim = tbc_pkg::DECIM_NUM / tbc_pkg::DECIM_W'(bw_eff);
      sin_v = tbc_pkg::tbc_sine(phase[tbc_pkg::PHASE_W-1 -: 4]);
      cos_v = tbc_pkg::tbc_sine(phase[tbc_pkg::PHASE_W-1 -: 4] + tbc_pkg::COS_OFFSET);
      next_phase = nb_step ? phase + ftw_eff : phase;
      next_decim_cnt = nb_step ? (nb_dump ? '0 : decim_cnt + 1'b1) : decim_cnt;
      for (int k = 0; k < tbc_pkg::N_IN; k++) begin
         sum_i = acc_i[k] + tbc_pkg::ACC_W'(
            $signed(dig_data_s[k*tbc_pkg::SAMPLE_W +: tbc_pkg::SAMPLE_W]) * cos_v);
         sum_q = acc_q[k] - tbc_pkg::ACC_W'(
            $signed(dig_data_s[k*tbc_pkg::SAMPLE_W +: tbc_pkg::SAMPLE_W]) * sin_v);
         next_acc_i[k] = nb_step ? (nb_dump ? '0 : sum_i) : acc_i[k];
         next_acc_q[k] = nb_step ? (nb_dump ? '0 : sum_q) : acc_q[k];
         next_hold[k] = (nb_dump && !nb_sending) ?
            {sum_i[tbc_pkg::ACC_W-1 -: tbc_pkg::NB_W], sum_q[tbc_pkg::ACC_W-1 -: tbc_pkg::NB_W]} :
            hold[k];
      end
      next_nb_sending = nb_sending;
      next_nb_idx = nb_idx;
      next_nb_overrun = nb_overrun;
      if (nb_push) begin
         next_nb_idx = nb_idx + 1'b1;
         if (nb_idx == tbc_pkg::IDX_LAST) begin
            next_nb_sending = 1'b0;
            next_nb_idx = '0;
         end
      end
      if (nb_dump) begin
         if (nb_sending) next_nb_overrun = 1'b1;
         else next_nb_sending = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         phase <= '0;
         decim <= tbc_pkg::DECIM_AT_MAX_BW;
         decim_cnt <= '0;
         nb_sending <= 1'b0;
         nb_idx <= '0;
         nb_overrun <= 1'b0;
         for (int k = 0; k < tbc_pkg::N_IN; k++) begin
            acc_i[k] <= '0;
            acc_q[k] <= '0;
            hold[k] <= '0;
         end
      end else begin
         phase <= next_phase;
         decim <= next_decim;
         decim_cnt <= next_decim_cnt;
         nb_sending <= next_nb_sending;
         nb_idx <= next_nb_idx;
         nb_overrun <= next_nb_overrun;
         acc_i <= next_acc_i;
         acc_q <= next_acc_q;
         hold <= next_hold;
      end
   end

   // ==========================================================
   // output buffer, fed by the selected mode only
   tbc_skid #(.W(tbc_pkg::OUT_W)) u_skid (
      .clk(clk),
      .reset(reset),
      .in_valid(mode_nb ? nb_push : wb_push),
      .in_data(mode_nb ? hold[nb_idx] : mem_rd_data),
      .in_ready(buf_in_ready),
      .out_valid(out_valid),
      .out_data(out_data),
      .out_ready(out_ready)
   );

   // ==========================================================
   // assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   chk_trig_starts_cap: assert property (
      wb_state == tbc_pkg::WB_ARMED && !mode_nb && trig_edge
      |=> wb_state == tbc_pkg::WB_CAPTURE && bitaddr == '0)
      else $error("trigger did not start capture");
   chk_full_stops: assert property (
      wb_state == tbc_pkg::WB_FULL |=> !mem_wr_en [*3])
      else $error("write after memory full");
   chk_mem_bound: assert property (
      mem_wr_en |-> mem_wr_bitaddr + tbc_pkg::BITADDR_W'(mem_wr_bits) <= tbc_pkg::MEM_BITS)
      else $error("write beyond per-input memory");
   chk_bits_step: assert property (
      wb_state == tbc_pkg::WB_CAPTURE && dig_valid_s
      |=> mem_wr_en && mem_wr_bits == $past(nbits) && bitaddr == $past(bitaddr) + mem_wr_bits)
      else $error("address step differs from bits per sample");
   chk_read_after_cap: assert property (
      mem_rd_en |-> $past(wb_state) == tbc_pkg::WB_READOUT)
      else $error("read outside readout");
   chk_one_mode: assert property (
      wb_state inside {tbc_pkg::WB_CAPTURE, tbc_pkg::WB_FULL, tbc_pkg::WB_READOUT}
      |-> !mode_nb && !nb_push)
      else $error("narrowband active during wideband use");
   chk_aligned_write: assert property (
      wb_state == tbc_pkg::WB_CAPTURE && dig_valid_s
      |=> mem_wr_data == $past(masked) && mem_wr_bitaddr == $past(bitaddr))
      else $error("inputs not written together");
   chk_decim_period: assert property (
      nb_dump |-> decim_cnt == decim - 1'b1 && decim == tbc_pkg::DECIM_NUM / $past(bw_eff))
      else $error("decimation count wrong");
   chk_tune_range: assert property (
      ftw_eff >= tbc_pkg::FTW_MIN && ftw_eff <= tbc_pkg::FTW_MAX)
      else $error("tuning outside range");
   chk_mux_start: assert property (
      nb_dump && !nb_sending |=> nb_sending && nb_idx == '0)
      else $error("multiplex did not start at input zero");
   chk_trig_ignored: assert property (
      trig_edge && wb_state inside {tbc_pkg::WB_FULL, tbc_pkg::WB_READOUT, tbc_pkg::WB_DONE}
      |=> wb_state != tbc_pkg::WB_CAPTURE)
      else $error("trigger accepted while not armed");

   cov_capture_full: cover property (
      wb_state == tbc_pkg::WB_CAPTURE ##1 wb_state == tbc_pkg::WB_FULL);
   cov_readout_done: cover property (
      wb_state == tbc_pkg::WB_READOUT ##1 wb_state == tbc_pkg::WB_DONE);
   cov_nb_frame: cover property (nb_push && nb_idx == tbc_pkg::IDX_LAST);
   cov_nb_overrun: cover property (nb_dump && nb_sending);
endmodule : tbc_capture

// >>> tbc_far_model.sv
module tbc_far_model (
   // clock and reset
   input wire logic clk,
   input wire logic reset,
   // capture memory read port
   input wire logic mem_rd_en,
   input wire logic [tbc_pkg::IDX_W-1:0] mem_rd_input,
   input wire logic [tbc_pkg::RD_ADDR_W-1:0] mem_rd_addr,
   output logic mem_rd_valid,
   output logic [tbc_pkg::OUT_W-1:0] mem_rd_data,
   // recorder back-pressure
   output logic out_ready
);
   timeunit 1ns;
   timeprecision 100ps;
   // ====================
   // memory answers one clock later; idle data inverts every clock, starting from the last word
   always @(posedge clk) begin
      if (reset) begin
         mem_rd_valid <= 1'b0;
         mem_rd_data <= 32'h0;
         out_ready <= 1'b0;
      end else begin
         mem_rd_valid <= mem_rd_en;
         mem_rd_data <= mem_rd_en ? {4'h0, mem_rd_input, mem_rd_addr} : ~mem_rd_data;
         out_ready <= ($urandom % 4) != 0;
      end
   end
endmodule : tbc_far_model

// >>> transient_buffer_capture_tb.sv
`define CHK(nm, exp, got) \
   begin \
      n_tests++; \
      if ((got) !== (exp)) begin \
         n_fail++; \
         $display("[ERR] %s expected %h seen %h", nm, exp, got); \
      end \
   end

module transient_buffer_capture_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic dig_valid, trigger, rearm, readout_start, mode_narrow, out_ready;
   logic [tbc_pkg::DIG_W-1:0] dig_data, mem_wr_data;
   logic [1:0] bits_sel;
   logic [tbc_pkg::PHASE_W-1:0] tune_ftw;
   logic [tbc_pkg::BW_W-1:0] bw_khz;
   logic mem_wr_en, mem_rd_en, mem_rd_valid, out_valid;
   logic [tbc_pkg::BITADDR_W-1:0] mem_wr_bitaddr, addr;
   logic [3:0] mem_wr_bits, nbits;
   logic [tbc_pkg::IDX_W-1:0] mem_rd_input;
   logic [tbc_pkg::RD_ADDR_W-1:0] mem_rd_addr;
   logic [tbc_pkg::OUT_W-1:0] mem_rd_data, out_data, oexp;
   logic wb_armed, wb_capturing, wb_full, wb_read_done, nb_active, nb_overrun;
   logic [tbc_pkg::DIG_W+tbc_pkg::BITADDR_W+3:0] wr_q[$], wexp;
   logic [tbc_pkg::OUT_W-1:0] out_q[$];
   int n_fail = 0;
   int n_tests = 0;

   tbc_capture u_dut (.clk, .reset, .dig_valid, .dig_data, .trigger, .rearm, .readout_start,
      .mode_narrow, .bits_sel, .tune_ftw, .bw_khz, .mem_wr_en, .mem_wr_bitaddr, .mem_wr_bits,
      .mem_wr_data, .mem_rd_en, .mem_rd_input, .mem_rd_addr, .mem_rd_valid, .mem_rd_data,
      .out_valid, .out_data, .out_ready, .wb_armed, .wb_capturing, .wb_full, .wb_read_done,
      .nb_active, .nb_overrun);

   tbc_far_model u_far (.clk, .reset, .mem_rd_en, .mem_rd_input, .mem_rd_addr, .mem_rd_valid,
      .mem_rd_data, .out_ready);

   initial begin
      forever #2 clk = ~clk;
   end

   // ====================
   // monitor: each result takes the oldest note
   always @(posedge clk) begin
      if (!reset && mem_wr_en) begin
         wexp = wr_q.size() != 0 ? wr_q.pop_front() : 'x;
         `CHK("wr_word", wexp, {mem_wr_bitaddr, mem_wr_bits, mem_wr_data})
      end
      if (!reset && out_valid && out_ready) begin
         oexp = out_q.size() != 0 ? out_q.pop_front() : 'x;
         `CHK("out_word", oexp, out_data)
      end
      if (!reset && mem_rd_en) `CHK("rd_en", 1'b0, mem_rd_en)
   end

   // ====================
   // tasks
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test

   task automatic do_reset(input logic narrow, input logic [1:0] bsel);
      reset <= 1'b1;
      mode_narrow <= narrow;
      bits_sel <= bsel;
      addr = '0;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      repeat (2) @(posedge clk);
      @(negedge clk);
      `CHK("armed", ~narrow, wb_armed)
      @(posedge clk);
   endtask : do_reset

   task automatic bounded(input logic narrow_wait);
      int k;
      for (k = 0; k < 400; k++) begin
         @(posedge clk);
         if (narrow_wait && wb_capturing === 1'b1) break;
         if (!narrow_wait && wr_q.size() == 0 && out_q.size() == 0) break;
      end
      if (k == 400) begin
         n_fail++;
         $display("[ERR] wait expected done seen timeout");
         end_of_test();
      end
   endtask : bounded

   // md 0: idle samples, 1: wideband capture, 2: narrowband zeros
   task automatic send(input int n, input int md);
      logic [tbc_pkg::DIG_W-1:0] d, e;
      logic [11:0] m;
      logic v;
      int i;
      int c;
      m = nbits == tbc_pkg::NBITS_12 ? 12'hFFF : nbits == tbc_pkg::NBITS_8 ? 12'hFF0 : 12'hF00;
      c = 0;
      for (i = 0; c < n && i < 4 * n; i++) begin
         @(posedge clk);
         v = ($urandom % 250) < 196;
         for (int k = 0; k < tbc_pkg::N_IN; k++) begin
            d[k*12 +: 12] = md == 2 ? 12'h000 : 12'($urandom);
            e[k*12 +: 12] = d[k*12 +: 12] & m;
         end
         dig_valid <= v;
         dig_data <= d;
         if (md != 0) trigger <= i[2];
         if (md == 1) begin
            rearm <= i[3];
            readout_start <= i[3];
         end
         if (v && md == 1) begin
            wr_q.push_back({addr, nbits, e});
            addr = addr + {25'h0, nbits};
         end
         if (v) c++;
         if (v && md == 2 && c % int'(tbc_pkg::DECIM_AT_MAX_BW) == 0)
            repeat (tbc_pkg::N_IN) out_q.push_back(32'h0);
      end
      @(posedge clk);
      dig_valid <= 1'b0;
      trigger <= 1'b0;
      rearm <= 1'b0;
      readout_start <= 1'b0;
   endtask : send

   // ====================
   // main sequence
   initial begin
      void'($urandom(32'hafc99492));
      {dig_valid, trigger, rearm, readout_start, mode_narrow} = 5'h0;
      dig_data = '0;
      bits_sel = 2'h0;
      bw_khz = 7'h7F;
      tune_ftw = $urandom;
      for (int s = 0; s < 4; s++) begin
         nbits = s == 0 ? tbc_pkg::NBITS_12 : s == 1 ? tbc_pkg::NBITS_8 : tbc_pkg::NBITS_4;
         do_reset(1'b0, 2'(s));
         send(6, 0);
         repeat (4) @(posedge clk);
         trigger <= 1'b1;
         bounded(1'b1);
         send(40, 1);
         bounded(1'b0);
         @(negedge clk);
         `CHK("capturing", 1'b1, wb_capturing)
         `CHK("full", 1'b0, wb_full)
         `CHK("narrow", 1'b0, nb_active)
         `CHK("armed_cap", 1'b0, wb_armed)
         `CHK("read_done", 1'b0, wb_read_done)
         @(posedge clk);
         $display("test wideband bits_sel %0d done", s);
      end
      nbits = tbc_pkg::NBITS_12;
      do_reset(1'b1, 2'h0);
      send(2 * int'(tbc_pkg::DECIM_AT_MAX_BW), 2);
      bounded(1'b0);
      @(negedge clk);
      `CHK("nb_active", 1'b1, nb_active)
      `CHK("overrun", 1'b0, nb_overrun)
      `CHK("wide", 1'b0, wb_capturing)
      `CHK("armed_nb", 1'b0, wb_armed)
      $display("test narrowband done");
      end_of_test();
   end
endmodule : transient_buffer_capture_tb
